//--- rtl/eep_pkg.sv
package eep_pkg;
    localparam int EEP_CLK_HZ = 40_000_000;
    localparam int EEP_PAGE_LEN = 32;
    localparam int EEP_MEM_LEN = 8192;
    localparam logic [3:0] EEP_DEV_CODE = 4'ha;
    localparam logic [12:0] EEP_PROT_BASE = 13'h1800;
    localparam int EEP_T_WR_MS = 10;
    localparam int EEP_WR_CYC = EEP_T_WR_MS * (EEP_CLK_HZ / 1000);
    localparam int EEP_SCL_QTR_NS = 625;
    localparam int EEP_SCL_QTR_CYC = EEP_SCL_QTR_NS * (EEP_CLK_HZ / 1_000_000) / 1000;
    localparam logic [5:0] EEP_SYNC_RST = 6'h30;
    localparam logic [1:0] EEP_SDA_RST = 2'h3;
    typedef enum logic [1:0] {
        EEP_OP_WRITE = 2'h0,
        EEP_OP_RDCUR = 2'h1,
        EEP_OP_RDRND = 2'h2,
        EEP_OP_POLL = 2'h3
    } eep_op_e;
endpackage

//--- rtl/eep_if.sv
interface eep_if;
    logic scl;
    logic sda_m_o, sda_m_oe, sda_s_o, sda_s_oe;
    logic sda;
    // open-drain wire with pull-up: any enabled low wins
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master(output scl, output sda_m_o, output sda_m_oe, input sda);
    modport slave(input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface

//--- rtl/eep_slave.sv
module eep_slave
    import eep_pkg::*;
#(
    parameter int WR_CYCLES = EEP_WR_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    eep_if.slave bus,
    input wire logic [2:0] chip_select_strap_inputs,
    input wire logic write_protect,
    output logic busy
);
    localparam int CW = $clog2(WR_CYCLES + 1);
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_RX = 3'h1,
        S_ACK = 3'h3,
        S_TX = 3'h2,
        S_RACK = 3'h6,
        S_WAIT = 3'h7
    } eep_sst_e;
    typedef enum logic [1:0] {K_DEV, K_HI, K_LO, K_DAT} eep_kind_e;

    logic [5:0] sy1_r, sy2_r;
    logic scl_d_r, sda_d_r;
    logic scl_s, sda_s, wp_s;
    logic [2:0] sel_s;
    logic scl_rise, scl_fall, start_c, stop_c;
    eep_sst_e st_r, st_nxt;
    eep_kind_e kind_r, kind_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [4:0] hi_r, hi_nxt;
    logic [12:0] ptr_r, ptr_nxt;
    logic [31:0] vld_r, vld_nxt;
    logic tx_r, tx_nxt, oe_r, oe_nxt, mack_r, mack_nxt;
    logic refuse_r, refuse_nxt, busy_r, busy_nxt;
    logic [CW-1:0] wcnt_r, wcnt_nxt;
    logic commit, buf_we, load_tx;
    logic [7:0] buf_r [EEP_PAGE_LEN];
    logic [7:0] mem_r [EEP_MEM_LEN];
    logic [7:0] rd_byte;

    // pins come from outside the clock domain: two flops before any use
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sy1_r <= EEP_SYNC_RST;
            sy2_r <= EEP_SYNC_RST;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sy1_r <= {bus.scl, bus.sda, write_protect, chip_select_strap_inputs};
            sy2_r <= sy1_r;
            scl_d_r <= sy2_r[5];
            sda_d_r <= sy2_r[4];
        end
    end

    // bus events seen on the synchronised lines
    assign scl_s = sy2_r[5];
    assign sda_s = sy2_r[4];
    assign wp_s = sy2_r[3];
    assign sel_s = sy2_r[2:0];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign rd_byte = mem_r[ptr_r];

    // protocol engine: next values
    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        hi_nxt = hi_r;
        ptr_nxt = ptr_r;
        vld_nxt = vld_r;
        tx_nxt = tx_r;
        oe_nxt = oe_r;
        mack_nxt = mack_r;
        refuse_nxt = refuse_r;
        busy_nxt = busy_r;
        wcnt_nxt = wcnt_r;
        commit = 1'b0;
        buf_we = 1'b0;
        load_tx = 1'b0;
        if (busy_r) begin
            st_nxt = S_IDLE;
            oe_nxt = 1'b0;
            if (wcnt_r == '0) begin
                busy_nxt = 1'b0;
            end else begin
                wcnt_nxt = wcnt_r - 1'b1;
            end
        end else if (stop_c) begin
            st_nxt = S_IDLE;
            oe_nxt = 1'b0;
            if (|vld_r && !refuse_r) begin
                commit = 1'b1;
                busy_nxt = 1'b1;
                wcnt_nxt = CW'(WR_CYCLES - 1);
            end
            vld_nxt = '0;
            refuse_nxt = 1'b0;
        end else if (start_c) begin
            // a restart drops any half page: only a stop commits
            st_nxt = S_RX;
            kind_nxt = K_DEV;
            bit_nxt = 4'h0;
            oe_nxt = 1'b0;
            vld_nxt = '0;
        end else begin
            case (st_r)
                S_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        st_nxt = S_ACK;
                        oe_nxt = 1'b1;
                        tx_nxt = 1'b0;
                        case (kind_r)
                            K_DEV: begin
                                if (sh_r[7:1] != {EEP_DEV_CODE, sel_s}) begin
                                    st_nxt = S_WAIT;
                                    oe_nxt = 1'b0;
                                end else begin
                                    tx_nxt = sh_r[0];
                                    kind_nxt = K_HI;
                                end
                            end
                            K_HI: begin
                                hi_nxt = sh_r[4:0];
                                kind_nxt = K_LO;
                            end
                            K_LO: begin
                                ptr_nxt = {hi_r, sh_r};
                                kind_nxt = K_DAT;
                            end
                            default: begin
                                if (wp_s && ptr_r >= EEP_PROT_BASE) begin
                                    refuse_nxt = 1'b1;
                                    st_nxt = S_WAIT;
                                    oe_nxt = 1'b0;
                                end else begin
                                    buf_we = 1'b1;
                                    vld_nxt = vld_r | (32'h1 << ptr_r[4:0]);
                                    ptr_nxt = {ptr_r[12:5], ptr_r[4:0] + 5'h1};
                                end
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        if (tx_r) begin
                            load_tx = 1'b1;
                        end else begin
                            st_nxt = S_RX;
                            bit_nxt = 4'h0;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_r == 4'h8) begin
                            st_nxt = S_RACK;
                            oe_nxt = 1'b0;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = !sh_r[6];
                            bit_nxt = bit_r + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        mack_nxt = !sda_s;
                    end else if (scl_fall) begin
                        if (mack_r) begin
                            load_tx = 1'b1;
                        end else begin
                            st_nxt = S_WAIT;
                        end
                    end
                end
                S_IDLE, S_WAIT: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    st_nxt = S_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
        if (load_tx) begin
            st_nxt = S_TX;
            sh_nxt = rd_byte;
            oe_nxt = !rd_byte[7];
            bit_nxt = 4'h1;
            ptr_nxt = ptr_r + 13'h1;
        end
    end

    // protocol engine: registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_r <= S_IDLE;
            kind_r <= K_DEV;
            bit_r <= 4'h0;
            sh_r <= 8'h0;
            hi_r <= 5'h0;
            ptr_r <= 13'h0;
            vld_r <= '0;
            tx_r <= 1'b0;
            oe_r <= 1'b0;
            mack_r <= 1'b0;
            refuse_r <= 1'b0;
            busy_r <= 1'b0;
            wcnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            hi_r <= hi_nxt;
            ptr_r <= ptr_nxt;
            vld_r <= vld_nxt;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
            mack_r <= mack_nxt;
            refuse_r <= refuse_nxt;
            busy_r <= busy_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    // array contents survive reset, like the cells they stand for
    always_ff @(posedge core_clk) begin
        if (buf_we) begin
            buf_r[ptr_r[4:0]] <= sh_r;
        end
        if (commit) begin
            for (int i = 0; i < EEP_PAGE_LEN; i++) begin
                if (vld_r[i]) begin
                    mem_r[{ptr_r[12:5], 5'(i)}] <= buf_r[i];
                end
            end
        end
    end

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = oe_r;
    assign busy = busy_r;
endmodule

//--- rtl/eep_master.sv
module eep_master
    import eep_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    eep_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire eep_op_e cmd_op,
    input wire logic [2:0] cmd_sel,
    input wire logic [12:0] cmd_addr,
    input wire logic [12:0] cmd_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    output logic done,
    output logic done_nack
);
    localparam int QW = $clog2(EEP_SCL_QTR_CYC + 1);
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_STA = 3'h1,
        M_DEV = 3'h3,
        M_AHI = 3'h2,
        M_ALO = 3'h6,
        M_WR = 3'h7,
        M_RD = 3'h5,
        M_STO = 3'h4
    } eep_mst_e;

    eep_mst_e mst_r, mst_nxt;
    eep_op_e op_r, op_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic [12:0] addr_r, addr_nxt, len_r, len_nxt;
    logic [1:0] ph_r, ph_nxt, sm_r;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, od_r, od_nxt, sd_r, sd_nxt;
    logic [QW-1:0] q_r, q_nxt;
    logic scl_r, scl_nxt, oe_r, oe_nxt, crdy_r, crdy_nxt, wrr_r, wrr_nxt;
    logic rs_r, rs_nxt, dvr_r, dvr_nxt, nk_r, nk_nxt, nack_r, nack_nxt;
    logic done_r, done_nxt, ov_r, ov_nxt, sv_r, sv_nxt;
    logic rdb, hold, tick, push, pop, is_rd, fail;

    // returning data line passes two flops
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sm_r <= EEP_SDA_RST;
        end else begin
            sm_r <= {sm_r[0], bus.sda};
        end
    end

    // sequencer: next values; scl is held low while a stream stalls
    always_comb begin
        mst_nxt = mst_r;
        op_nxt = op_r;
        sel_nxt = sel_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        q_nxt = q_r;
        scl_nxt = scl_r;
        oe_nxt = oe_r;
        crdy_nxt = crdy_r;
        wrr_nxt = wrr_r;
        rs_nxt = rs_r;
        dvr_nxt = dvr_r;
        nk_nxt = nk_r;
        nack_nxt = nack_r;
        done_nxt = 1'b0;
        push = 1'b0;
        tick = 1'b0;
        fail = 1'b0;
        is_rd = (mst_r == M_RD);
        // read bit only after restart or current read
        rdb = (op_r == EEP_OP_RDCUR) || rs_r;
        hold = (mst_r == M_WR && wrr_r) || (is_rd && bit_r == 4'h0 && ph_r == 2'h0 && sv_r);
        if (mst_r == M_IDLE || hold) begin
            q_nxt = '0;
        end else if (q_r == QW'(EEP_SCL_QTR_CYC - 1)) begin
            q_nxt = '0;
            tick = 1'b1;
        end else begin
            q_nxt = q_r + 1'b1;
        end
        if (mst_r == M_IDLE) begin
            if (cmd_valid && crdy_r) begin
                mst_nxt = M_STA;
                crdy_nxt = 1'b0;
                op_nxt = cmd_op;
                sel_nxt = cmd_sel;
                addr_nxt = cmd_addr;
                len_nxt = cmd_len;
                rs_nxt = 1'b0;
                nack_nxt = 1'b0;
                ph_nxt = 2'h0;
            end
        end else if (mst_r == M_WR && wrr_r) begin
            if (wr_valid) begin
                sh_nxt = wr_data;
                wrr_nxt = 1'b0;
            end
        end else if (tick) begin
            ph_nxt = ph_r + 2'h1;
            case (ph_r)
                2'h0: begin
                    if (mst_r == M_STA) begin
                        oe_nxt = 1'b0;
                    end else if (mst_r == M_STO) begin
                        oe_nxt = 1'b1;
                    end else if (bit_r != 4'h8) begin
                        oe_nxt = !is_rd && !sh_r[7];
                    end else begin
                        // ack all but the last byte
                        oe_nxt = is_rd && len_r != 13'h1;
                    end
                end
                2'h1: scl_nxt = 1'b1;
                2'h2: begin
                    if (mst_r == M_STA) begin
                        oe_nxt = 1'b1;
                    end else if (mst_r == M_STO) begin
                        oe_nxt = 1'b0;
                    end else if (bit_r != 4'h8) begin
                        if (is_rd) begin
                            sh_nxt = {sh_r[6:0], sm_r[1]};
                        end
                    end else begin
                        nk_nxt = sm_r[1];
                    end
                end
                default: begin
                    if (mst_r != M_STO) begin
                        scl_nxt = 1'b0;
                    end
                    bit_nxt = 4'h0;
                    case (mst_r)
                        M_STA: begin
                            mst_nxt = M_DEV;
                            sh_nxt = {EEP_DEV_CODE, sel_r, rdb};
                            dvr_nxt = rdb;
                        end
                        M_STO: begin
                            mst_nxt = M_IDLE;
                            crdy_nxt = 1'b1;
                            done_nxt = 1'b1;
                        end
                        default: begin
                            if (bit_r != 4'h8) begin
                                bit_nxt = bit_r + 4'h1;
                                if (!is_rd) begin
                                    sh_nxt = {sh_r[6:0], 1'b0};
                                end
                            end else if (nk_r && !is_rd) begin
                                fail = 1'b1;
                            end else begin
                                case (mst_r)
                                    M_DEV: begin
                                        // poll ends at the address ack
                                        if (op_r == EEP_OP_POLL) begin
                                            mst_nxt = M_STO;
                                        end else if (dvr_r) begin
                                            mst_nxt = M_RD;
                                        end else begin
                                            mst_nxt = M_AHI;
                                            sh_nxt = {3'h0, addr_r[12:8]};
                                        end
                                    end
                                    M_AHI: begin
                                        mst_nxt = M_ALO;
                                        sh_nxt = addr_r[7:0];
                                    end
                                    M_ALO: begin
                                        if (op_r == EEP_OP_WRITE) begin
                                            mst_nxt = M_WR;
                                            wrr_nxt = 1'b1;
                                        end else begin
                                            mst_nxt = M_STA;
                                            rs_nxt = 1'b1;
                                        end
                                    end
                                    default: begin
                                        push = is_rd;
                                        len_nxt = len_r - 13'h1;
                                        if (len_r == 13'h1) begin
                                            mst_nxt = M_STO;
                                        end else begin
                                            wrr_nxt = !is_rd;
                                        end
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            endcase
        end
        if (fail) begin
            mst_nxt = M_STO;
            nack_nxt = 1'b1;
        end
    end

    // two-entry read buffer: output stage plus skid entry
    always_comb begin
        pop = ov_r && rd_ready;
        ov_nxt = ov_r;
        od_nxt = od_r;
        sv_nxt = sv_r;
        sd_nxt = sd_r;
        if (pop) begin
            ov_nxt = sv_r;
            od_nxt = sd_r;
            sv_nxt = 1'b0;
        end
        if (push) begin
            if (!ov_nxt) begin
                ov_nxt = 1'b1;
                od_nxt = sh_r;
            end else begin
                sv_nxt = 1'b1;
                sd_nxt = sh_r;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mst_r <= M_IDLE;
            op_r <= EEP_OP_WRITE;
            sel_r <= 3'h0;
            addr_r <= 13'h0;
            len_r <= 13'h0;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h0;
            q_r <= '0;
            scl_r <= 1'b1;
            oe_r <= 1'b0;
            crdy_r <= 1'b1;
            wrr_r <= 1'b0;
            rs_r <= 1'b0;
            dvr_r <= 1'b0;
            nk_r <= 1'b0;
            nack_r <= 1'b0;
            done_r <= 1'b0;
            ov_r <= 1'b0;
            od_r <= 8'h0;
            sv_r <= 1'b0;
            sd_r <= 8'h0;
        end else begin
            mst_r <= mst_nxt;
            op_r <= op_nxt;
            sel_r <= sel_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            q_r <= q_nxt;
            scl_r <= scl_nxt;
            oe_r <= oe_nxt;
            crdy_r <= crdy_nxt;
            wrr_r <= wrr_nxt;
            rs_r <= rs_nxt;
            dvr_r <= dvr_nxt;
            nk_r <= nk_nxt;
            nack_r <= nack_nxt;
            done_r <= done_nxt;
            ov_r <= ov_nxt;
            od_r <= od_nxt;
            sv_r <= sv_nxt;
            sd_r <= sd_nxt;
        end
    end

    assign bus.scl = scl_r;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = oe_r;
    assign cmd_ready = crdy_r;
    assign wr_ready = wrr_r;
    assign rd_valid = ov_r;
    assign rd_data = od_r;
    assign done = done_r;
    assign done_nack = nack_r;
endmodule

//--- tb/eep_chk.sv
module eep_chk #(
    parameter int WR_CYCLES = 2000
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_o,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cnt_r, cnt_nxt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // count busy cycles, too long for a repetition
    always_comb cnt_nxt = busy ? cnt_r + 1 : 32'h0000_0000;
    always_ff @(posedge core_clk) cnt_r <= nrst ? cnt_nxt : 32'h0000_0000;
    a_busy_mute: assert property (busy |-> !sda_s_oe)
        else $error("slave drives while busy");
    a_busy_len: assert property ($fell(busy) |-> cnt_r == 32'(WR_CYCLES))
        else $error("write cycle length wrong");
    a_busy_idle: assert property ($rose(busy) |-> scl && sda)
        else $error("write cycle began off a stop");
    a_oe_on_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave changed sda with scl high");
    a_ack_holds: assert property ($rose(sda_s_oe) |=> sda_s_oe[*8])
        else $error("slave pull too short");
    a_scl_high: assert property ($rose(scl) |-> scl[*6])
        else $error("scl high too short");
    a_scl_low: assert property ($fell(scl) |-> !scl[*6])
        else $error("scl low too short");
    a_open_drain: assert property (!sda_m_o && !sda_s_o)
        else $error("sda driven high");
endmodule

//--- tb/eep_test.sv
module eep_test;
    timeunit 1ns;
    timeprecision 100ps;
    import eep_pkg::*;
    localparam int WR = 2000;
    logic core_clk = 0, nrst = 0, wp = 0, cmd_valid = 0, wr_valid = 1, rd_ready = 1;
    logic cmd_ready, wr_ready, rd_valid, done, done_nack, busy;
    eep_op_e cmd_op = EEP_OP_POLL;
    logic [2:0] cmd_sel = 3'h5;
    logic [12:0] cmd_addr = 13'h0000, cmd_len = 13'h0001;
    logic [7:0] wr_data = 8'h00, rd_data, ev [8192];
    logic [7:0] wq [$], rq [$];
    int n_fail = 0, checked = 0, wi = 0, cyc = 0;
    eep_if bus_if();
    eep_slave #(.WR_CYCLES(WR)) eep_slave_inst (.core_clk(core_clk), .nrst(nrst), .bus(bus_if),
        .chip_select_strap_inputs(3'h5), .write_protect(wp), .busy(busy));
    eep_master eep_master_inst (.core_clk(core_clk), .nrst(nrst), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .done(done), .done_nack(done_nack));
    eep_chk #(.WR_CYCLES(WR)) eep_chk_inst (.core_clk(core_clk), .nrst(nrst), .scl(bus_if.scl),
        .sda(bus_if.sda), .sda_m_o(bus_if.sda_m_o), .sda_s_o(bus_if.sda_s_o),
        .sda_s_oe(bus_if.sda_s_oe), .busy(busy));
    always #12.5 core_clk = ~core_clk;
    // stall the reader a quarter of the time so the buffer fills
    always @(negedge core_clk) begin
        wr_data <= wq.size() > wi ? wq[wi] : 8'h00;
        rd_ready <= !(cyc[11] && cyc[10]);
    end
    // stream bookkeeping and hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (wr_valid && wr_ready) wi <= wi + 1;
        if (rd_valid && rd_ready) rq.push_back(rd_data);
        // ceiling sits a little above the expected length of the whole run
        if (cyc == 98000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input eep_op_e op, input logic [12:0] a, input int n, input logic [2:0] s);
        cmd_op = op;
        cmd_addr = a;
        cmd_len = 13'(n);
        cmd_sel = s;
        cmd_valid = 1;
        @(negedge core_clk);
        cmd_valid = 0;
        while (done !== 1'b1) @(negedge core_clk);
    endtask
    // write, then poll until the device answers again
    task automatic wr(input logic [12:0] a, input int n, input logic p);
        int k;
        wq.delete();
        wi = 0;
        for (k = 0; k < n; k++) begin
            wq.push_back(8'(a + k * 7));
            if (!p) ev[{a[12:5], 5'(a[4:0] + k)}] = wq[k];
        end
        @(negedge core_clk);
        run(EEP_OP_WRITE, a, n, 3'h5);
        chk({7'h00, done_nack}, {7'h00, p});
        run(EEP_OP_POLL, a, 1, 3'h5);
        chk({7'h00, done_nack}, {7'h00, !p});
        for (k = 0; k < 20 && done_nack; k++) run(EEP_OP_POLL, a, 1, 3'h5);
        chk({7'h00, done_nack}, 8'h00);
    endtask
    task automatic rd(input eep_op_e op, input logic [12:0] a, input int n);
        int k;
        rq.delete();
        run(op, a, n, 3'h5);
        // the reader may still be stalled after done: drain the buffer first
        for (k = 0; k < 1100 && rd_valid; k++) @(negedge core_clk);
        chk(8'(rq.size()), 8'(n));
        for (k = 0; k < n; k++) chk(rq[k], ev[13'(a + k)]);
    endtask
    task automatic wrap_up();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        nrst = 1;
        @(negedge core_clk);
        wr(13'h005f, 33, 0);
        rd(EEP_OP_RDRND, 13'h0050, 15);
        rd(EEP_OP_RDCUR, 13'h005f, 1);
        wr(13'h1fff, 1, 0);
        wr(13'h0000, 1, 0);
        rd(EEP_OP_RDRND, 13'h1fff, 2);
        wp = 1;
        wr(13'h1fff, 1, 1);
        rd(EEP_OP_RDRND, 13'h1fff, 1);
        run(EEP_OP_POLL, 13'h0000, 1, 3'h2);
        chk({7'h00, done_nack}, 8'h01);
        wrap_up();
    end
endmodule
